// ===== design/cet_top.sv
// error flags, error counters, time stamp and test modes of the can controller
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
module cet_top #(
   parameter int STAMP_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // controller state
   input wire logic [1:0] op_mode_i,
   input wire logic sleep_i,
   input wire logic bit_tick_i,
   input wire logic [7:0] rx_err_cnt_i,
   input wire logic [7:0] tx_err_cnt_i,
   // protocol events, one-cycle pulses, with the overrun mailbox number and the mailbox mode levels
   input wire logic stuff_err_i,
   input wire logic form_err_i,
   input wire logic ack_err_i,
   input wire logic crc_err_i,
   input wire logic rec_bit_err_i,
   input wire logic dom_bit_err_i,
   input wire logic ack_delim_err_i,
   input wire logic overload_det_i,
   input wire logic overrun_i,
   input wire logic [4:0] overrun_mb_i,
   input wire logic overrun_fifo_i,
   input wire logic fifo_mode_i,
   input wire logic overwrite_mode_i,
   input wire logic rx_store_i,
   // bit stream
   input wire logic ctrl_tx_i,
   output logic ctrl_rx_o,
   input wire logic bus_receive_pin_i,
   output logic bus_transmit_pin_o,
   // status toward the controller
   output logic rx_complete_req_o,
   output logic listen_only_o,
   output logic self_ack_o,
   output logic [7:0] stamp_low_field_o,
   output logic [7:0] stamp_high_field_o,
   output logic stamp_we_o
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [2:0] err_status_ff;
   logic [6:0] ec_accum_ff;
   logic [6:0] ec_first_ff;
   logic error_display_select_ff;
   logic [7:0] test_control_ff;
   logic [cet_pkg::PS_W-1:0] stamp_prescale_ff;
   logic [STAMP_W-1:0] stamp_cnt;
   logic rx_meta_ff;
   logic rx_sync_ff;
   logic [5:0] dom_cnt_ff;
   logic lock_armed_ff;
   logic ack_ff;
   logic [31:0] rd_dat_ff;
   logic bus_req;
   logic wr_lane0;
   logic in_reset;
   logic test_enable;
   logic [1:0] test_select;
   logic listen_only;
   logic ext_loop;
   logic int_loop;
   logic rx_line;
   logic [6:0] ec_set;
   logic [6:0] ec_clr;
   logic [2:0] st_set;
   logic [2:0] st_clr;
   logic [6:0] ec_first_kept;
   logic lock_hit;
   logic [31:0] nxt_rd_dat;
   logic [7:0] ec_clr_wide;
   logic [7:0] st_clr_wide;
   localparam logic [5:0] BUS_LOCK_LAST = 6'(cet_pkg::BUS_LOCK_BITS - 6'h01);

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // zero bits written by software select which flags to clear
   function automatic logic [7:0] zero_clear(input logic hit, input logic [7:0] wdat);
      zero_clear = hit ? ~wdat : 8'h00;
   endfunction

   // which mailboxes report overrun depends on mailbox mode
   function automatic logic overrun_counts(input logic fifo_mode, input logic [4:0] mb,
                                           input logic is_fifo);
      overrun_counts = !fifo_mode || is_fifo || (mb <= cet_pkg::FIFO_LAST_MB);
   endfunction

   // ------------------------------------------------------------
   // mode and test decoding
   // ------------------------------------------------------------
   assign in_reset = (op_mode_i == cet_pkg::MODE_RESET);
   assign test_enable = test_control_ff[cet_pkg::TC_ENABLE];
   assign test_select = test_control_ff[cet_pkg::TC_SEL_LSB +: 2];
   // with test disabled the select field has no effect at all
   assign listen_only = test_enable && (test_select == cet_pkg::TEST_LISTEN);
   assign ext_loop = test_enable && (test_select == cet_pkg::TEST_EXT_LOOP);
   assign int_loop = test_enable && (test_select == cet_pkg::TEST_INT_LOOP);

   // ------------------------------------------------------------
   // receive pin synchroniser and bit routing
   // ------------------------------------------------------------
   // pin is asynchronous to clk_i; two stages before any use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_meta_ff <= cet_pkg::RECESSIVE;
         rx_sync_ff <= cet_pkg::RECESSIVE;
      end else begin
         rx_meta_ff <= bus_receive_pin_i;
         rx_sync_ff <= rx_meta_ff;
      end
   end

   // internal loopback ignores the external pin entirely
   assign rx_line = int_loop ? ctrl_tx_i : rx_sync_ff;

   // registered outputs cost one cycle of delay on each path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_rx_o <= cet_pkg::RECESSIVE;
         bus_transmit_pin_o <= cet_pkg::RECESSIVE;
         listen_only_o <= 1'b0;
         self_ack_o <= 1'b0;
      end else begin
         ctrl_rx_o <= rx_line;
         // listen only and internal loopback keep the pin recessive
         bus_transmit_pin_o <= (listen_only || int_loop) ? cet_pkg::RECESSIVE
                                                         : ctrl_tx_i;
         // engine suppresses ack, overload and active error flags
         listen_only_o <= listen_only;
         self_ack_o <= ext_loop || int_loop;
      end
   end

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

   // one wait state; ack drops in the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= bus_req;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      nxt_rd_dat = 32'h0000_0000;
      if (wb_adr_i == cet_pkg::OFS_ERR_STATUS) begin
         nxt_rd_dat[2:0] = err_status_ff;
      end else if (wb_adr_i == cet_pkg::OFS_RX_ERR_CNT) begin
         nxt_rd_dat[7:0] = rx_err_cnt_i;
      end else if (wb_adr_i == cet_pkg::OFS_TX_ERR_CNT) begin
         nxt_rd_dat[7:0] = tx_err_cnt_i;
      end else if (wb_adr_i == cet_pkg::OFS_ERR_CODE) begin
         nxt_rd_dat[6:0] = error_display_select_ff ? ec_accum_ff : ec_first_ff;
         nxt_rd_dat[cet_pkg::EC_DISPLAY] = error_display_select_ff;
      end else if (wb_adr_i == cet_pkg::OFS_STAMP) begin
         nxt_rd_dat[STAMP_W-1:0] = stamp_cnt;
      end else if (wb_adr_i == cet_pkg::OFS_TEST_CTRL) begin
         nxt_rd_dat[7:0] = test_control_ff;
      end else if (wb_adr_i == cet_pkg::OFS_STAMP_CFG) begin
         nxt_rd_dat[cet_pkg::PS_W-1:0] = stamp_prescale_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_dat_ff <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         rd_dat_ff <= nxt_rd_dat;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rd_dat_ff;

   // ------------------------------------------------------------
   // plain control registers
   // ------------------------------------------------------------
   // test control returns to its reset value in reset mode
   always_ff @(posedge clk_i) begin
      if (rst_i || in_reset) begin
         test_control_ff <= cet_pkg::TEST_CTRL_RST;
      end else if (wr_lane0 && wb_adr_i == cet_pkg::OFS_TEST_CTRL) begin
         test_control_ff <= wb_dat_i[7:0];
      end
   end

   // display select survives reset mode; software keeps to reset/halt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         error_display_select_ff <= 1'b0;
      end else if (wr_lane0 && wb_adr_i == cet_pkg::OFS_ERR_CODE) begin
         error_display_select_ff <= wb_dat_i[cet_pkg::EC_DISPLAY];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stamp_prescale_ff <= cet_pkg::STAMP_CFG_RST;
      end else if (wr_lane0 && wb_adr_i == cet_pkg::OFS_STAMP_CFG) begin
         stamp_prescale_ff <= wb_dat_i[cet_pkg::PS_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // error code flags
   // ------------------------------------------------------------
   // all conditions of one instant land together
   assign ec_set = {ack_delim_err_i, dom_bit_err_i, rec_bit_err_i, crc_err_i,
                    ack_err_i, form_err_i, stuff_err_i};
   // a clear that leaves other bits alone relies on ones written there
   assign ec_clr_wide = zero_clear(wr_lane0 && wb_adr_i == cet_pkg::OFS_ERR_CODE,
                                   wb_dat_i[7:0]);
   assign ec_clr = ec_clr_wide[6:0];
   assign ec_first_kept = ec_first_ff & ~ec_clr;

   always_ff @(posedge clk_i) begin
      if (rst_i || in_reset) begin
         ec_accum_ff <= cet_pkg::ERR_CODE_RST;
      end else begin
         ec_accum_ff <= (ec_accum_ff & ~ec_clr) | ec_set;
      end
   end

   // first code freezes until software clears what it holds
   always_ff @(posedge clk_i) begin
      if (rst_i || in_reset) begin
         ec_first_ff <= cet_pkg::ERR_CODE_RST;
      end else if (ec_first_kept == cet_pkg::ERR_CODE_RST) begin
         ec_first_ff <= ec_set;
      end else begin
         ec_first_ff <= ec_first_kept;
      end
   end

   // ------------------------------------------------------------
   // overrun, overload and bus lock flags
   // ------------------------------------------------------------
   assign lock_hit = bit_tick_i && (rx_line != cet_pkg::RECESSIVE) && lock_armed_ff &&
                     (op_mode_i == cet_pkg::MODE_OPERATE) &&
                     (dom_cnt_ff == BUS_LOCK_LAST);
   assign st_set[cet_pkg::ST_OVERRUN] = overrun_i && !overwrite_mode_i &&
      overrun_counts(fifo_mode_i, overrun_mb_i, overrun_fifo_i);
   assign st_set[cet_pkg::ST_OVERLOAD] = overload_det_i;
   assign st_set[cet_pkg::ST_BUS_LOCK] = lock_hit;
   assign st_clr_wide = zero_clear(wr_lane0 && wb_adr_i == cet_pkg::OFS_ERR_STATUS,
                                   wb_dat_i[7:0]);
   assign st_clr = st_clr_wide[2:0];

   // set beats a coinciding software clear
   always_ff @(posedge clk_i) begin
      if (rst_i || in_reset) begin
         err_status_ff <= cet_pkg::ERR_STATUS_RST;
      end else begin
         err_status_ff <= (err_status_ff & ~st_clr) | st_set;
      end
   end

   // overwrite mode reports through the completion request instead
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_complete_req_o <= 1'b0;
      end else begin
         rx_complete_req_o <= overrun_i && overwrite_mode_i;
      end
   end

   // consecutive dominant bits, saturating below the lock count
   always_ff @(posedge clk_i) begin
      if (rst_i || in_reset) begin
         dom_cnt_ff <= 6'h00;
      end else if (bit_tick_i) begin
         if (rx_line == cet_pkg::RECESSIVE) begin
            dom_cnt_ff <= 6'h00;
         end else if (dom_cnt_ff != BUS_LOCK_LAST) begin
            dom_cnt_ff <= 6'(dom_cnt_ff + 6'h01);
         end
      end
   end

   // disarmed on detection; rearmed once flag is clear and bus frees
   always_ff @(posedge clk_i) begin
      if (rst_i || in_reset) begin
         lock_armed_ff <= 1'b1;
      end else if (lock_hit) begin
         lock_armed_ff <= 1'b0;
      end else if (!err_status_ff[cet_pkg::ST_BUS_LOCK] && bit_tick_i &&
                   rx_line == cet_pkg::RECESSIVE) begin
         lock_armed_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // time stamp
   // ------------------------------------------------------------
   cet_stamp #(
      .CNT_W(STAMP_W),
      .PS_W(cet_pkg::PS_W)
   ) u_stamp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bit_tick_i(bit_tick_i),
      .prescale_i(stamp_prescale_ff),
      .hold_i(sleep_i || op_mode_i == cet_pkg::MODE_HALT),
      .clear_i(in_reset),
      .count_o(stamp_cnt)
   );

   // mailbox write takes the stamp of the storing cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stamp_low_field_o <= 8'h00;
         stamp_high_field_o <= 8'h00;
         stamp_we_o <= 1'b0;
      end else begin
         stamp_we_o <= rx_store_i;
         if (rx_store_i) begin
            stamp_low_field_o <= stamp_cnt[7:0];
            stamp_high_field_o <= stamp_cnt[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_overrun_flag_set: assert property (st_set[cet_pkg::ST_OVERRUN] && !in_reset
      |=> err_status_ff[cet_pkg::ST_OVERRUN]) else $error("overrun flag not set");
   a_overwrite_no_flag: assert property (overrun_i && overwrite_mode_i
      |-> !st_set[cet_pkg::ST_OVERRUN] ##1 rx_complete_req_o)
      else $error("overwrite handled wrong");
   a_fifo_mb_filter: assert property (overrun_i && fifo_mode_i && !overrun_fifo_i &&
      overrun_mb_i > cet_pkg::FIFO_LAST_MB |-> !st_set[cet_pkg::ST_OVERRUN])
      else $error("fifo mode overrun filter wrong");
   a_overload_flag: assert property (overload_det_i && !in_reset
      |=> err_status_ff[cet_pkg::ST_OVERLOAD]) else $error("overload flag missing");
   a_bus_lock_set: assert property (lock_hit && !in_reset
      |=> err_status_ff[cet_pkg::ST_BUS_LOCK] && !lock_armed_ff)
      else $error("bus lock not flagged");
   a_bus_lock_rearm: assert property (err_status_ff[cet_pkg::ST_BUS_LOCK] && !in_reset
      |-> !lock_armed_ff) else $error("bus lock armed while flagged");
   a_count_read_live: assert property (bus_req && !wb_we_i &&
      wb_adr_i == cet_pkg::OFS_RX_ERR_CNT |=> wb_ack_o && wb_dat_o[7:0] == $past(rx_err_cnt_i))
      else $error("receive count read mismatch");
   a_errors_all_set: assert property (!in_reset && ec_set != 7'h00
      |=> (ec_accum_ff & $past(ec_set)) == $past(ec_set))
      else $error("error flags lost");
   a_first_code_hold: assert property (ec_first_ff != 7'h00 && ec_clr == 7'h00 && !in_reset
      |=> ec_first_ff == $past(ec_first_ff)) else $error("first code changed");
   a_stamp_hold: assert property (!in_reset && (sleep_i || op_mode_i == cet_pkg::MODE_HALT)
      |=> $stable(stamp_cnt)) else $error("stamp moved while held");
   a_stamp_copy: assert property (rx_store_i
      |=> stamp_we_o && {stamp_high_field_o, stamp_low_field_o} == $past(stamp_cnt))
      else $error("stamp copy wrong");
   a_int_loop_pin: assert property (int_loop || listen_only
      |=> bus_transmit_pin_o == cet_pkg::RECESSIVE) else $error("pin driven in test");

   c_overrun_seen: cover property (st_set[cet_pkg::ST_OVERRUN] ##1 wb_ack_o);
   c_bus_lock_seen: cover property (lock_hit);
   c_loop_self_ack: cover property (int_loop ##1 self_ack_o && ctrl_rx_o == $past(ctrl_tx_i));
   c_accum_display: cover property (error_display_select_ff && ec_accum_ff != ec_first_ff);
endmodule

// ===== common/cet_pkg.sv
// shared constants for the can error, stamp and test block
package cet_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_ERR_STATUS = 8'h00;
   localparam logic [7:0] OFS_RX_ERR_CNT = 8'h04;
   localparam logic [7:0] OFS_TX_ERR_CNT = 8'h08;
   localparam logic [7:0] OFS_ERR_CODE = 8'h0c;
   localparam logic [7:0] OFS_STAMP = 8'h10;
   localparam logic [7:0] OFS_TEST_CTRL = 8'h14;
   localparam logic [7:0] OFS_STAMP_CFG = 8'h18;
   // ------------------------------------------------------------
   // operating modes and test selections
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_OPERATE = 2'h0;
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam logic [1:0] MODE_HALT = 2'h2;
   localparam logic [1:0] TEST_LISTEN = 2'h1;
   localparam logic [1:0] TEST_EXT_LOOP = 2'h2;
   localparam logic [1:0] TEST_INT_LOOP = 2'h3;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int ST_OVERRUN = 0;
   localparam int ST_OVERLOAD = 1;
   localparam int ST_BUS_LOCK = 2;
   localparam int EC_FLAGS = 7;
   localparam int EC_DISPLAY = 7;
   localparam int TC_SEL_LSB = 0;
   localparam int TC_ENABLE = 7;
   localparam int PS_W = 2;
   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [2:0] ERR_STATUS_RST = 3'h0;
   localparam logic [6:0] ERR_CODE_RST = 7'h00;
   localparam logic [7:0] TEST_CTRL_RST = 8'h00;
   localparam logic [1:0] STAMP_CFG_RST = 2'h0;
   localparam logic [15:0] STAMP_RST = 16'h0000;
   localparam logic [5:0] BUS_LOCK_BITS = 6'h20;
   localparam logic [4:0] FIFO_LAST_MB = 5'h17;
   localparam logic RECESSIVE = 1'b1;
endpackage

// ===== design/cet_stamp.sv
// free-running time stamp counter with bit-time prescaler
`timescale 1ns/10ps
module cet_stamp #(
   parameter int CNT_W = 16,
   parameter int PS_W = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bit_tick_i,
   input wire logic [PS_W-1:0] prescale_i,
   input wire logic hold_i,
   input wire logic clear_i,
   output logic [CNT_W-1:0] count_o
);
   localparam int DIV_W = (1 << PS_W);

   logic [DIV_W-1:0] div_ff;
   logic [DIV_W-1:0] div_last;
   logic ref_tick;

   // ------------------------------------------------------------
   // reference tick
   // ------------------------------------------------------------
   // multiple of bit time is two to the prescale value
   assign div_last = DIV_W'((1 << prescale_i) - 1);
   assign ref_tick = bit_tick_i && (div_ff >= div_last);

   // divider runs only while the counter may advance
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         div_ff <= '0;
      end else if (bit_tick_i && !hold_i) begin
         div_ff <= ref_tick ? '0 : DIV_W'(div_ff + 1'b1);
      end
   end

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   // reset mode clears, sleep and halt freeze
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count_o <= CNT_W'(cet_pkg::STAMP_RST);
      end else if (ref_tick && !hold_i) begin
         count_o <= CNT_W'(count_o + 1'b1);
      end
   end
endmodule

// ===== tb/cet_bus_model.sv
// bus and transceiver model facing the block's pins
`timescale 1ns/10ps
module cet_bus_model (
   input wire logic clk_i,
   input wire logic tx_pin_i,
   input wire logic lock_i,
   output logic rx_pin_o
);
   // wired-and bus: the node reads its own bit back, lock_i is a node stuck dominant
   always_ff @(posedge clk_i) begin
      rx_pin_o <= tx_pin_i & ~lock_i;
   end
endmodule

// ===== tb/can_error_status_timestamp_test_test.sv
// self-checking bench for the can error, stamp and test block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module can_error_status_timestamp_test_test;
   logic clk_i, rst_i, cyc, stb, we, bt, ctx, lock, fifo, ovw, slp;
   logic ack, crx, prx, ptx, rxreq, lo, sack, swe;
   logic [7:0] adr, sl, sh, rec;
   logic [31:0] wdat, dat_o, q;
   logic [1:0] mode;
   logic [4:0] mb;
   logic [10:0] ev;
   logic [15:0] cap = 16'h0000;
   int mismatches, checked;
   int nreq = 0;
   cet_top i_cet_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .op_mode_i(mode), .sleep_i(slp), .bit_tick_i(bt),
      .rx_err_cnt_i(rec), .tx_err_cnt_i(8'h33), .stuff_err_i(ev[0]), .form_err_i(ev[1]),
      .ack_err_i(ev[2]), .crc_err_i(ev[3]), .rec_bit_err_i(ev[4]), .dom_bit_err_i(ev[5]),
      .ack_delim_err_i(ev[6]), .overload_det_i(ev[7]), .overrun_i(ev[8]), .overrun_mb_i(mb),
      .overrun_fifo_i(ev[10]), .fifo_mode_i(fifo), .overwrite_mode_i(ovw), .rx_store_i(ev[9]),
      .ctrl_tx_i(ctx), .ctrl_rx_o(crx), .bus_receive_pin_i(prx), .bus_transmit_pin_o(ptx),
      .rx_complete_req_o(rxreq), .listen_only_o(lo), .self_ack_o(sack),
      .stamp_low_field_o(sl), .stamp_high_field_o(sh), .stamp_we_o(swe));
   cet_bus_model i_cet_bus_model (.clk_i(clk_i), .tx_pin_i(ptx), .lock_i(lock), .rx_pin_o(prx));
   // 10 mhz clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // pulse outputs only live one cycle, so catch them at the edge
   always @(posedge clk_i) begin
      if (rxreq === 1'b1) nreq <= nreq + 1;
      if (swe === 1'b1) cap <= {sh, sl};
   end
   // ------------------------------------------------------------
   // bus and event tasks
   // ------------------------------------------------------------
   // request held up to the rising edge that samples ack; read data taken there
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat_o;
      {cyc, stb} <= 2'h0;
      if (n >= 20) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK($sformatf("offset %h", a), e, q)
   endtask
   task automatic fire(input logic [10:0] m);
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= '0;
   endtask
   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge clk_i);
         bt <= 1'b1;
         @(posedge clk_i);
         bt <= 1'b0;
      end
   endtask
   task automatic summarize();
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rst_i, cyc, stb, we, bt, ctx, lock, fifo, ovw, slp} = 10'h210;
      {adr, wdat, ev, mb, mode} = '0;
      {mismatches, checked} = '0;
      rec = 8'h5a;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(cet_pkg::OFS_ERR_STATUS, 32'h0);
      rd(8'h40, 32'h0);
      wb(1'b1, cet_pkg::OFS_TX_ERR_CNT, 32'hff);
      rd(cet_pkg::OFS_RX_ERR_CNT, 32'h5a);
      rec <= 8'ha5;
      rd(cet_pkg::OFS_RX_ERR_CNT, 32'ha5);
      rd(cet_pkg::OFS_TX_ERR_CNT, 32'h33);
      mb <= 5'h1f;
      fire(11'h100);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h1);
      wb(1'b1, cet_pkg::OFS_ERR_STATUS, 32'h6);
      fifo <= 1'b1;
      mb <= 5'h18;
      fire(11'h100);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h0);
      mb <= 5'h17;
      fire(11'h100);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h1);
      wb(1'b1, cet_pkg::OFS_ERR_STATUS, 32'h6);
      mb <= 5'h18;
      fire(11'h500);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h1);
      wb(1'b1, cet_pkg::OFS_ERR_STATUS, 32'h6);
      ovw <= 1'b1;
      fire(11'h100);
      fire(11'h080);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h2);
      `CHK("completion requests", 1, nreq)
      mode <= cet_pkg::MODE_RESET;
      wb(1'b1, cet_pkg::OFS_ERR_CODE, 32'h80);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h0);
      mode <= cet_pkg::MODE_OPERATE;
      fire(11'h009);
      rd(cet_pkg::OFS_ERR_CODE, 32'h89);
      fire(11'h040);
      rd(cet_pkg::OFS_ERR_CODE, 32'hc9);
      wb(1'b1, cet_pkg::OFS_ERR_CODE, 32'hfe);
      rd(cet_pkg::OFS_ERR_CODE, 32'hc8);
      fire(11'h036);
      rd(cet_pkg::OFS_ERR_CODE, 32'hfe);
      mode <= cet_pkg::MODE_RESET;
      wb(1'b1, cet_pkg::OFS_ERR_CODE, 32'h0);
      wb(1'b1, cet_pkg::OFS_STAMP_CFG, 32'h1);
      rd(cet_pkg::OFS_ERR_CODE, 32'h0);
      mode <= cet_pkg::MODE_OPERATE;
      fire(11'h005);
      fire(11'h002);
      rd(cet_pkg::OFS_ERR_CODE, 32'h05);
      ticks(6);
      rd(cet_pkg::OFS_STAMP, 32'h3);
      mode <= cet_pkg::MODE_HALT;
      ticks(4);
      rd(cet_pkg::OFS_STAMP, 32'h3);
      mode <= cet_pkg::MODE_OPERATE;
      slp <= 1'b1;
      ticks(4);
      rd(cet_pkg::OFS_STAMP, 32'h3);
      slp <= 1'b0;
      fire(11'h200);
      rd(cet_pkg::OFS_STAMP, 32'h3);
      `CHK("stamp copy", 16'h0003, cap)
      mode <= cet_pkg::MODE_RESET;
      rd(cet_pkg::OFS_STAMP, 32'h0);
      mode <= cet_pkg::MODE_OPERATE;
      lock <= 1'b1;
      ticks(32);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h0);
      ticks(1);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h4);
      wb(1'b1, cet_pkg::OFS_ERR_STATUS, 32'h0);
      ticks(40);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h0);
      lock <= 1'b0;
      ticks(3);
      lock <= 1'b1;
      ticks(35);
      rd(cet_pkg::OFS_ERR_STATUS, 32'h4);
      mode <= cet_pkg::MODE_HALT;
      ctx <= 1'b0;
      // outputs are registered one edge after the write lands
      wb(1'b1, cet_pkg::OFS_TEST_CTRL, 32'h03);
      @(posedge clk_i);
      `CHK("normal node", 4'h0, {lo, sack, ptx, crx})
      wb(1'b1, cet_pkg::OFS_TEST_CTRL, 32'h81); // controller drives dominant, pin stays recessive
      @(posedge clk_i);
      `CHK("listen only", 3'h5, {lo, sack, ptx})
      wb(1'b1, cet_pkg::OFS_TEST_CTRL, 32'h82);
      @(posedge clk_i);
      `CHK("outer loop", 3'h2, {lo, sack, ptx})
      ctx <= 1'b1;
      wb(1'b1, cet_pkg::OFS_TEST_CTRL, 32'h83);
      @(posedge clk_i);
      `CHK("inner loop", 4'h7, {lo, sack, ptx, crx})
      summarize();
   end
   // hang guard
   initial begin
      repeat (30000) @(posedge clk_i);
      mismatches++;
      summarize();
   end
endmodule
